//--- src/gpc_pkg.sv
package gpc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int JOY_PINS = 4;
    localparam int KBC_PIN = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef logic [7:0] gpc_cfg_t;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_JOY1_X = 8'h27;
    localparam logic [7:0] IDX_JOY1_Y = 8'h28;
    localparam logic [7:0] IDX_JOY2_X = 8'h29;
    localparam logic [7:0] IDX_JOY2_Y = 8'h2A;
    localparam logic [7:0] IDX_KBC_FDD = 8'h2B;
    localparam logic [7:0] IDX_PIN_DATA = 8'h3F;
    localparam logic [7:0] ADDR_JOY1_X = {IDX_JOY1_X[5:0], 2'b00};
    localparam logic [7:0] ADDR_JOY1_Y = {IDX_JOY1_Y[5:0], 2'b00};
    localparam logic [7:0] ADDR_JOY2_X = {IDX_JOY2_X[5:0], 2'b00};
    localparam logic [7:0] ADDR_JOY2_Y = {IDX_JOY2_Y[5:0], 2'b00};
    localparam logic [7:0] ADDR_KBC_FDD = {IDX_KBC_FDD[5:0], 2'b00};
    localparam logic [7:0] ADDR_PIN_DATA = {IDX_PIN_DATA[5:0], 2'b00};
    localparam logic [3:0] SLOT_DATA = 4'h5;
    localparam logic [3:0] SLOT_NONE = 4'hF;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam gpc_cfg_t CFG_RESET = 8'h01;
    localparam gpc_cfg_t MASK_SINGLE = 8'h87;
    localparam gpc_cfg_t MASK_DUAL = 8'h8F;
    localparam int BIT_DIR = 0;
    localparam int BIT_POL = 1;
    localparam int BIT_ALT = 2;
    localparam int BIT_ODT = 7;
    localparam int ALT_LO = 2;
    localparam int ALT_HI = 3;
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_KBC = 2'h1;
    localparam logic [1:0] SEL_FDD = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpc_pkg

//--- src/gpc_reg_if.sv
`timescale 1ns/1ps

interface gpc_reg_if;
    logic wrEn;
    logic [gpc_pkg::ADDR_W-1:0] wrAddr;
    logic [gpc_pkg::DATA_W-1:0] wrData;
    logic [3:0] wrStrb;
    logic wrHit;
    logic [gpc_pkg::ADDR_W-1:0] rdAddr;
    logic [gpc_pkg::DATA_W-1:0] rdData;
    logic rdHit;

    modport slave (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrHit, rdData, rdHit);
    modport regs (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrHit, rdData, rdHit);
endinterface : gpc_reg_if

//--- src/gpc_axil_slave.sv
`timescale 1ns/1ps

module gpc_axil_slave (
    input logic clock,
    input logic sys_rst,
    input logic [gpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [gpc_pkg::DATA_W-1:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [gpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gpc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    gpc_reg_if.slave bus
);
    logic awHeld_reg;
    logic wHeld_reg;
    logic rdPend_reg;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are held until both are in, then committed once.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpc_pkg::RESP_OKAY;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bus.wrEn <= 1'b0;
            bus.wrAddr <= '0;
            bus.wrData <= '0;
            bus.wrStrb <= '0;
        end else begin
            bus.wrEn <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                bus.wrAddr <= s_axi_awaddr;
                awHeld_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                bus.wrData <= s_axi_wdata;
                bus.wrStrb <= s_axi_wstrb;
                wHeld_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
                bus.wrEn <= 1'b1;
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bus.wrHit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gpc_pkg::RESP_OKAY;
            rdPend_reg <= 1'b0;
            bus.rdAddr <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                bus.rdAddr <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                rdPend_reg <= 1'b1;
            end
            if (rdPend_reg) begin
                rdPend_reg <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= bus.rdData;
                s_axi_rresp <= bus.rdHit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : gpc_axil_slave

//--- src/gpc_pin_cell.sv
`timescale 1ns/1ps

module gpc_pin_cell (
    input gpc_pkg::gpc_cfg_t cfg,
    input logic gpioOut,
    input logic altSel,
    input logic altIsOut,
    input logic altOut,
    input logic pinIn,
    output logic padOutNext,
    output logic padOeNext,
    output logic readVal
);
    logic driving;
    logic value;

    always_comb begin
        driving = altSel ? altIsOut : !cfg[gpc_pkg::BIT_DIR];
        value = (altSel ? altOut : gpioOut) ^ cfg[gpc_pkg::BIT_POL];
        readVal = pinIn ^ cfg[gpc_pkg::BIT_POL];
        padOutNext = cfg[gpc_pkg::BIT_ODT] ? 1'b0 : value;
        padOeNext = driving && (cfg[gpc_pkg::BIT_ODT] ? !value : 1'b1);
    end
endmodule : gpc_pin_cell

//--- src/gpc_pin_cfg_top.sv
// How it works
// - On the GPIO path, config bit 0 high makes the pin an input; low lets it drive.
// - Config bit 1 high inverts the pin's logical value both ways.
// - Config bit 7 high gives open-drain drive, low gives push-pull.
// - Every config register loads 0x01 at reset: input, normal, push-pull, GPIO.
// - Pin 1.4 bit 2 high routes the pin to joystick one X timing.
// - Pin 1.5 bit 2 high routes the pin to joystick one Y timing.
// - Pin 1.6 bit 2 high routes the pin to joystick two X timing.
// - Pin 1.7 bit 2 high routes the pin to joystick two Y timing.
// - Pin 2.0 bits 3:2: 00 GPIO, 01 keyboard port bit, 10 floppy select.
`timescale 1ns/1ps

module gpc_pin_cfg_top (
    input logic clock,
    input logic sys_rst,
    input logic [gpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [gpc_pkg::DATA_W-1:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [gpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gpc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [gpc_pkg::PIN_COUNT-1:0] padIn,
    output logic [gpc_pkg::PIN_COUNT-1:0] padOut,
    output logic [gpc_pkg::PIN_COUNT-1:0] padOe,
    output logic joystickOneXTiming,
    output logic joystickOneYTiming,
    output logic joystickTwoXTiming,
    output logic joystickTwoYTiming,
    output logic kbcPortOneBitSeven,
    input logic kbcPortOneBitSevenDrive,
    input logic floppyDriveSelectOne_n
);
    localparam int PINS = gpc_pkg::PIN_COUNT;

    gpc_pkg::gpc_cfg_t pinCfg_reg [PINS];
    logic [PINS-1:0] dataOut_reg;
    logic [PINS-1:0] padOut_reg;
    logic [PINS-1:0] padOe_reg;
    logic [gpc_pkg::JOY_PINS-1:0] joyTiming_reg;
    logic kbcRead_reg;
    logic [PINS-1:0] padOutNext;
    logic [PINS-1:0] padOeNext;
    logic [PINS-1:0] readVal;
    logic [PINS-1:0] altSel;
    logic [PINS-1:0] altIsOut;
    logic [PINS-1:0] altOut;
    logic [PINS-1:0] polOut;
    logic [PINS-1:0] altPol;
    logic [1:0] dualSel;
    logic [3:0] wrSlot;
    logic [3:0] rdSlot;

    gpc_reg_if regBus ();

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    gpc_axil_slave u_slave (
        .clock(clock),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .bus(regBus.slave)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Only aligned word addresses hit; anything else answers with an error.
    function automatic logic [3:0] addrSlot(input logic [gpc_pkg::ADDR_W-1:0] a);
        logic [3:0] s;
        s = gpc_pkg::SLOT_NONE;
        if (a[1:0] == 2'h0) begin
            case (a)
                gpc_pkg::ADDR_JOY1_X: s = 4'h0;
                gpc_pkg::ADDR_JOY1_Y: s = 4'h1;
                gpc_pkg::ADDR_JOY2_X: s = 4'h2;
                gpc_pkg::ADDR_JOY2_Y: s = 4'h3;
                gpc_pkg::ADDR_KBC_FDD: s = 4'h4;
                gpc_pkg::ADDR_PIN_DATA: s = gpc_pkg::SLOT_DATA;
                default: s = gpc_pkg::SLOT_NONE;
            endcase
        end
        return s;
    endfunction : addrSlot

    assign wrSlot = addrSlot(regBus.wrAddr);
    assign rdSlot = addrSlot(regBus.rdAddr);
    assign regBus.wrHit = (wrSlot != gpc_pkg::SLOT_NONE);
    assign regBus.rdHit = (rdSlot != gpc_pkg::SLOT_NONE);

    always_comb begin
        regBus.rdData = '0;
        if (rdSlot < gpc_pkg::SLOT_DATA) begin
            regBus.rdData[7:0] = pinCfg_reg[rdSlot[2:0]];
        end else if (rdSlot == gpc_pkg::SLOT_DATA) begin
            regBus.rdData[PINS-1:0] = readVal;
        end
    end

    // ------------------------------------------------------------
    // Output data register
    // ------------------------------------------------------------
    // Writes set the GPIO output values; reads return the sensed pin values.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dataOut_reg <= '0;
        end else if (regBus.wrEn && wrSlot == gpc_pkg::SLOT_DATA && regBus.wrStrb[0]) begin
            dataOut_reg <= regBus.wrData[PINS-1:0];
        end
    end

    assign dualSel = pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::ALT_HI:gpc_pkg::ALT_LO];

    // ------------------------------------------------------------
    // Per-pin configuration and pad logic
    // ------------------------------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        localparam gpc_pkg::gpc_cfg_t MASK =
            (i == gpc_pkg::KBC_PIN) ? gpc_pkg::MASK_DUAL : gpc_pkg::MASK_SINGLE;

        always_ff @(posedge clock) begin
            if (sys_rst) begin
                pinCfg_reg[i] <= gpc_pkg::CFG_RESET;
            end else if (regBus.wrEn && wrSlot == 4'(i) && regBus.wrStrb[0]) begin
                pinCfg_reg[i] <= regBus.wrData[7:0] & MASK;
            end
        end

        if (i < gpc_pkg::JOY_PINS) begin : g_joy
            always_comb begin
                altSel[i] = pinCfg_reg[i][gpc_pkg::BIT_ALT];
                altIsOut[i] = 1'b0;
                altOut[i] = 1'b0;
            end

            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    joyTiming_reg[i] <= 1'b0;
                end else begin
                    joyTiming_reg[i] <= altSel[i] ? readVal[i] : 1'b0;
                end
            end
        end else begin : g_dual
            always_comb begin
                altSel[i] = (dualSel == gpc_pkg::SEL_KBC) || (dualSel == gpc_pkg::SEL_FDD);
                altIsOut[i] = 1'b1;
                altOut[i] = (dualSel == gpc_pkg::SEL_FDD) ? floppyDriveSelectOne_n
                                                          : kbcPortOneBitSevenDrive;
            end
        end

        assign polOut[i] = dataOut_reg[i] ^ pinCfg_reg[i][gpc_pkg::BIT_POL];
        assign altPol[i] = altOut[i] ^ pinCfg_reg[i][gpc_pkg::BIT_POL];

        gpc_pin_cell u_cell (
            .cfg(pinCfg_reg[i]),
            .gpioOut(dataOut_reg[i]),
            .altSel(altSel[i]),
            .altIsOut(altIsOut[i]),
            .altOut(altOut[i]),
            .pinIn(padIn[i]),
            .padOutNext(padOutNext[i]),
            .padOeNext(padOeNext[i]),
            .readVal(readVal[i])
        );
    end

    // ------------------------------------------------------------
    // Registered pin and function outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            padOut_reg <= '0;
            padOe_reg <= '0;
        end else begin
            padOut_reg <= padOutNext;
            padOe_reg <= padOeNext;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            kbcRead_reg <= 1'b1;
        end else begin
            kbcRead_reg <= (dualSel == gpc_pkg::SEL_KBC) ? readVal[gpc_pkg::KBC_PIN] : 1'b1;
        end
    end

    assign padOut = padOut_reg;
    assign padOe = padOe_reg;
    assign joystickOneXTiming = joyTiming_reg[0];
    assign joystickOneYTiming = joyTiming_reg[1];
    assign joystickTwoXTiming = joyTiming_reg[2];
    assign joystickTwoYTiming = joyTiming_reg[3];
    assign kbcPortOneBitSeven = kbcRead_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking

    default disable iff (sys_rst);

    for (genvar i = 0; i < PINS; i++) begin : g_chk
        localparam gpc_pkg::gpc_cfg_t MASK =
            (i == gpc_pkg::KBC_PIN) ? gpc_pkg::MASK_DUAL : gpc_pkg::MASK_SINGLE;

        a_dir_input_release:
        assert property (pinCfg_reg[i][gpc_pkg::BIT_DIR] && !altSel[i] |=> !padOe_reg[i])
            else $error("Input pin is driving.");

        a_pol_output_value:
        assert property (!pinCfg_reg[i][gpc_pkg::BIT_DIR] && !altSel[i]
                         && !pinCfg_reg[i][gpc_pkg::BIT_ODT]
                         |=> padOe_reg[i] && padOut_reg[i] == $past(polOut[i]))
            else $error("Push-pull output value or enable wrong.");

        a_od_never_high:
        assert property (pinCfg_reg[i][gpc_pkg::BIT_ODT] |=> !padOut_reg[i])
            else $error("Open-drain pin drove high.");

        a_od_release_one:
        assert property (pinCfg_reg[i][gpc_pkg::BIT_ODT] && !pinCfg_reg[i][gpc_pkg::BIT_DIR]
                         && !altSel[i]
                         |=> padOe_reg[i] == !$past(polOut[i]))
            else $error("Open-drain enable does not follow value.");

        a_reset_cfg_value:
        assert property ($fell(sys_rst) |-> pinCfg_reg[i] == gpc_pkg::CFG_RESET)
            else $error("Config register not at reset value.");

        a_rsvd_bits_clear:
        assert property ((pinCfg_reg[i] & ~MASK) == 8'h00)
            else $error("Reserved config bit is set.");

        a_write_masked_load:
        assert property (regBus.wrEn && wrSlot == 4'(i) && regBus.wrStrb[0]
                         |=> pinCfg_reg[i] == ($past(regBus.wrData[7:0]) & MASK))
            else $error("Config write not stored with mask.");

        if (i < gpc_pkg::JOY_PINS) begin : g_joy_chk
            a_joy_route_input:
            assert property (pinCfg_reg[i][gpc_pkg::BIT_ALT]
                             |=> joyTiming_reg[i] == $past(readVal[i]))
                else $error("Joystick timing input not routed.");

            a_joy_gpio_quiet:
            assert property (!pinCfg_reg[i][gpc_pkg::BIT_ALT] |=> !joyTiming_reg[i])
                else $error("Joystick timing active while GPIO.");

            a_alt_owns_pin:
            assert property (pinCfg_reg[i][gpc_pkg::BIT_ALT] |=> !padOe_reg[i])
                else $error("GPIO path drives a joystick pin.");
        end
    end

    a_fdd_drive_select:
    assert property (dualSel == gpc_pkg::SEL_FDD && !pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_ODT]
                     |=> padOe_reg[gpc_pkg::KBC_PIN]
                         && padOut_reg[gpc_pkg::KBC_PIN] == $past(altPol[gpc_pkg::KBC_PIN]))
        else $error("Floppy select not driven on pin.");

    a_kbc_read_route:
    assert property (dualSel == gpc_pkg::SEL_KBC
                     |=> kbcRead_reg == $past(readVal[gpc_pkg::KBC_PIN]))
        else $error("Keyboard port bit not routed.");

    a_kbc_alt_owns:
    assert property (dualSel == gpc_pkg::SEL_KBC && pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_DIR]
                     && !pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_ODT]
                     |=> padOe_reg[gpc_pkg::KBC_PIN])
        else $error("Keyboard function does not own pin.");

    // ------------------------------------------------------------
    // Pin 2.0 select and reset checks
    // ------------------------------------------------------------
    // The reserved select code must fall back to the plain GPIO path.
    a_rsvd_sel_gpio:
    assert property (dualSel == gpc_pkg::SEL_RSVD
                     && pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_DIR]
                     |=> !padOe_reg[gpc_pkg::KBC_PIN])
        else $error("Reserved select drives an input pin.");

    a_kbc_drive_value:
    assert property (dualSel == gpc_pkg::SEL_KBC
                     && !pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_ODT]
                     |=> padOut_reg[gpc_pkg::KBC_PIN] == $past(altPol[gpc_pkg::KBC_PIN]))
        else $error("Keyboard drive value not on pin.");

    a_kbc_idle_high:
    assert property (dualSel != gpc_pkg::SEL_KBC |=> kbcRead_reg)
        else $error("Keyboard port bit not idle high.");

    a_fdd_od_release:
    assert property (dualSel == gpc_pkg::SEL_FDD
                     && pinCfg_reg[gpc_pkg::KBC_PIN][gpc_pkg::BIT_ODT]
                     |=> padOe_reg[gpc_pkg::KBC_PIN] == !$past(altPol[gpc_pkg::KBC_PIN]))
        else $error("Open-drain floppy select enable wrong.");

    a_reset_pads_idle:
    assert property ($fell(sys_rst) |-> padOe_reg == '0 && kbcRead_reg
                     && joyTiming_reg == '0)
        else $error("Pin outputs not idle after reset.");

    c_joy_selected: cover property (pinCfg_reg[0][gpc_pkg::BIT_ALT] ##1 joyTiming_reg[0]);
    c_fdd_selected: cover property (dualSel == gpc_pkg::SEL_FDD ##1 padOe_reg[gpc_pkg::KBC_PIN]);
    c_kbc_selected: cover property (dualSel == gpc_pkg::SEL_KBC ##1 !kbcRead_reg);
    c_od_drive_low: cover property (pinCfg_reg[1][gpc_pkg::BIT_ODT] ##1 padOe_reg[1]);
    c_rsvd_selected: cover property (dualSel == gpc_pkg::SEL_RSVD
                                     ##1 !padOe_reg[gpc_pkg::KBC_PIN]);

endmodule : gpc_pin_cfg_top

//--- testbench/gpc_pin_partner.sv
`timescale 1ns/1ps

module gpc_pin_partner (
    input wire logic [4:0] padOut,
    input wire logic [4:0] padOe,
    input wire logic [4:0] extLevel,
    output logic [4:0] padIn
);
    // The device wins a wire it drives; otherwise the far-side source sets it.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : extLevel[i];
        end
    end
endmodule : gpc_pin_partner

//--- testbench/test_gpio_pin_config_group1_2.sv
`timescale 1ns/1ps

module test_gpio_pin_config_group1_2;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, c;
    logic [31:0] wdata = 32'h0, rdata, w, got;
    logic [3:0] wstrb = 4'h0, joy, eJoy;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, kbcOut, kbcDrv = 1'b0, floppySel = 1'b1;
    logic eKbc, v, drv, isJoy, isKbc, isFdd;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] padIn, padOut, padOe, ext = 5'h00, dat, eOut, eOe, sense;
    logic [7:0] cfg [5];
    logic [7:0] addrs [5];
    int fail_count = 0, num_checks = 0, cycles = 0;

    gpc_pin_cfg_top u_gpc_pin_cfg_top (
        .clock(clock), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .joystickOneXTiming(joy[0]), .joystickOneYTiming(joy[1]),
        .joystickTwoXTiming(joy[2]), .joystickTwoYTiming(joy[3]),
        .kbcPortOneBitSeven(kbcOut), .kbcPortOneBitSevenDrive(kbcDrv),
        .floppyDriveSelectOne_n(floppySel)
    );

    gpc_pin_partner u_gpc_pin_partner (
        .padOut(padOut), .padOe(padOe), .extLevel(ext), .padIn(padIn)
    );

    initial begin
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        got = rdata;
        resp = rresp;
    endtask : axr

    task automatic reset_check();
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check({27'h0, padOe}, 32'h0);
        check({28'h0, joy}, 32'h0);
        check({31'h0, kbcOut}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            axr(addrs[i]);
            check(got, 32'h00000001);
            check({30'h0, resp}, 32'h0);
        end
    endtask : reset_check

    initial begin
        void'($urandom(38));
        for (int i = 0; i < 5; i++) addrs[i] = 8'((8'h27 + i) * 4);
        reset_check();
        axr(8'h00);
        check({got[29:0], resp}, 32'h2);
        axr(8'h9D);
        check({got[29:0], resp}, 32'h2);
        axw(8'h40, 32'hFF, 4'hF);
        check({30'h0, resp}, 32'h2);
        axw(addrs[0], 32'hFF, 4'hE);
        axr(addrs[0]);
        check(got, 32'h00000001);
        for (int n = 0; n < 24; n++) begin
            for (int i = 0; i < 5; i++) begin
                w = $urandom();
                cfg[i] = w[7:0];
                axw(addrs[i], w, 4'hF);
            end
            dat = 5'($urandom());
            axw(8'hFC, {27'h0, dat}, 4'hF);
            ext <= 5'($urandom());
            kbcDrv <= 1'($urandom());
            floppySel <= 1'($urandom());
            repeat (4) @(posedge clock);
            for (int i = 0; i < 5; i++) begin
                c = cfg[i];
                isJoy = i < 4 && c[2];
                isKbc = i == 4 && c[3:2] == 2'h1;
                isFdd = i == 4 && c[3:2] == 2'h2;
                v = (isKbc ? kbcDrv : isFdd ? floppySel : isJoy ? 1'b0 : dat[i]) ^ c[1];
                drv = !isJoy && (isKbc || isFdd || !c[0]);
                eOut[i] = !c[7] && v;
                eOe[i] = drv && !(c[7] && v);
                sense[i] = (eOe[i] ? eOut[i] : ext[i]) ^ c[1];
                if (i < 4) eJoy[i] = isJoy && sense[i];
                eKbc = isKbc ? sense[4] : 1'b1;
            end
            check({27'h0, padOut}, {27'h0, eOut});
            check({27'h0, padOe}, {27'h0, eOe});
            check({28'h0, joy}, {28'h0, eJoy});
            check({31'h0, kbcOut}, {31'h0, eKbc});
            axr(8'hFC);
            check(got, {27'h0, sense});
            for (int i = 0; i < 5; i++) begin
                axr(addrs[i]);
                check(got, {24'h0, cfg[i] & (i == 4 ? 8'h8F : 8'h87)});
            end
        end
        reset_check();
        stop_test();
    end
endmodule : test_gpio_pin_config_group1_2
